// ==== logic/deep_sleep_pkg.sv ====
package deep_sleep_pkg;

    // ************************************************************
    // Register indices and byte addresses
    // ************************************************************
    localparam int unsigned     ADDR_W          = 8;
    localparam logic [7:0]      IDX_CTRL_A      = 8'h11;
    localparam logic [7:0]      IDX_CTRL_B      = 8'h13;
    localparam logic [7:0]      IDX_CTRL_C      = 8'h14;
    localparam logic [7:0]      IDX_STATUS      = 8'h18;
    localparam logic [7:0]      ADDR_CTRL_A     = 8'h44;
    localparam logic [7:0]      ADDR_CTRL_B     = 8'h4C;
    localparam logic [7:0]      ADDR_CTRL_C     = 8'h50;
    localparam logic [7:0]      ADDR_STATUS     = 8'h60;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int unsigned     A_PD_SLOW_CLK   = 6;
    localparam int unsigned     B_HIGH_THRESH   = 15;
    localparam int unsigned     B_UDS_SLOW_CLK  = 0;
    localparam int unsigned     C_METHOD_CPU    = 6;
    localparam int unsigned     C_MANUAL_REQ    = 5;
    localparam int unsigned     C_NV_ACCESS     = 4;
    localparam int unsigned     C_SLEEP_EN      = 3;
    localparam int unsigned     C_RX_TERM_OFF   = 2;
    localparam int unsigned     C_LONG_DELAY    = 1;
    localparam int unsigned     C_DET_POL_LOW   = 0;
    localparam int unsigned     S_SLEEPING      = 0;
    localparam int unsigned     S_MANUAL        = 1;
    localparam int unsigned     S_SLOW_CLK      = 2;
    localparam int unsigned     S_ENERGY        = 3;
    localparam int unsigned     S_QUALIFIED     = 4;
    localparam int unsigned     S_POWERED_DOWN  = 5;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [15:0]     CTRL_RESET      = 16'h0000;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int unsigned     CLK_PERIOD_NS   = 10;
    localparam int unsigned     MIN_DELAY_NS    = 160;
    localparam int unsigned     INC_DELAY_NS    = 40000;
    localparam int unsigned     MIN_DELAY_CYC   = (MIN_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned     INC_DELAY_CYC   = (INC_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic [1:0] {
        ST_AWAKE,
        ST_AUTO_SLEEP,
        ST_MANUAL_SLEEP
    } sleep_state_t;

endpackage

// ==== logic/energy_delay_if.sv ====
`timescale 1ns/1ps
`default_nettype none

interface energy_delay_if;
    logic energy;
    logic long_sel;
    logic qualified;

    modport owner (output energy, output long_sel, input qualified);
    modport timer (input energy, input long_sel, output qualified);
endinterface

`default_nettype wire

// ==== logic/energy_delay_timer.sv ====
`timescale 1ns/1ps
`default_nettype none

module energy_delay_timer #(
    parameter int unsigned MIN_CYC = 16,
    parameter int unsigned INC_CYC = 4000,
    parameter int unsigned CNT_W   = 16
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    energy_delay_if.timer          dly
);

    logic [CNT_W-1:0] remain;

    initial begin
        if (MIN_CYC < 1 || INC_CYC < MIN_CYC || INC_CYC >= (2 ** CNT_W))
            $error("energy_delay_timer: delay counts do not fit the counter");
    end

    // ************************************************************
    // Hold-off after loss of energy
    // ************************************************************
    // Reload while energy is present so the hold-off always starts full.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            remain <= '0;
        end else if (dly.energy) begin
            remain <= dly.long_sel ? CNT_W'(INC_CYC) : CNT_W'(MIN_CYC);
        end else if (remain != '0) begin
            remain <= remain - 1'b1;
        end
    end

    assign dly.qualified = dly.energy || (remain != '0);

endmodule

`default_nettype wire

// ==== logic/deep_sleep_power_control.sv ====
// Functional notes
// - Power-down slow-clock bit swaps in slow oscillator.
// - Deep-sleep slow-clock bit uses slow oscillator asleep.
// - Threshold bit enables high-threshold pulse comparator.
// - Processor method sleeps only on manual request.
// - Writing manual request one with sleep enabled and processor method enters manual sleep.
// - Manual sleep left only by hardware reset.
// - Non-volatile bit enables retained register copy.
// - Sleep enable allows sleep; indicator shows energy.
// - Sleep disabled forces indicator asserted.
// - Termination bit disables receive termination only.
// - Polarity bit makes indicator active low.
// - Delay bit selects hold-off after energy loss.
`timescale 1ns/1ps
`default_nettype none

module deep_sleep_power_control
    import deep_sleep_pkg::*;
#(
    parameter int unsigned INC_CYC = deep_sleep_pkg::INC_DELAY_CYC,
    parameter int unsigned MIN_CYC = deep_sleep_pkg::MIN_DELAY_CYC
) (
    input  wire logic                              pclk,
    input  wire logic                              presetn,
    input  wire logic                              psel,
    input  wire logic                              penable,
    input  wire logic                              pwrite,
    input  wire logic [deep_sleep_pkg::ADDR_W-1:0] paddr,
    input  wire logic [31:0]                       pwdata,
    input  wire logic [3:0]                        pstrb,
    output logic [31:0]                            prdata,
    output logic                                   pready,
    output logic                                   pslverr,
    input  wire logic                              cable_energy,
    input  wire logic                              powered_down,
    output logic                                   slow_clock_select,
    output logic                                   deep_sleep,
    output logic                                   cable_energy_indicator,
    output logic                                   high_threshold_enable,
    output logic                                   rx_termination_disable,
    output logic                                   nv_copy_enable
);

    import deep_sleep_pkg::*;

    logic [15:0]  ctrl_a;
    logic [15:0]  ctrl_b;
    logic [15:0]  ctrl_c;
    logic [1:0]   energy_sync;
    logic [1:0]   pd_sync;
    logic         energy;
    logic         pd;
    sleep_state_t state;
    sleep_state_t next_state;
    logic         wr_en;
    logic [15:0]  status;
    logic         indicator_true;

    energy_delay_if dly ();

    function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
        return (a == ADDR_CTRL_A) || (a == ADDR_CTRL_B) ||
               (a == ADDR_CTRL_C) || (a == ADDR_STATUS);
    endfunction

    function automatic logic [15:0] merge(input logic [15:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0]  st);
        logic [15:0] r;
        r = old;
        if (st[0]) r[7:0] = wd[7:0];
        if (st[1]) r[15:8] = wd[15:8];
        return r;
    endfunction

    initial begin
        if (MIN_CYC < 1 || INC_CYC < MIN_CYC)
            $error("deep_sleep_power_control: bad delay counts");
    end

    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            energy_sync <= 2'h0;
            pd_sync     <= 2'h0;
        end else begin
            energy_sync <= {energy_sync[0], cable_energy};
            pd_sync     <= {pd_sync[0], powered_down};
        end
    end

    assign energy = energy_sync[1];
    assign pd     = pd_sync[1];

    // ************************************************************
    // APB slave
    // ************************************************************
    // Zero wait states: every access completes in its first access cycle.
    assign pready = 1'b1;
    assign wr_en  = psel && penable && pwrite && is_mapped(paddr);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_a <= CTRL_RESET;
            ctrl_b <= CTRL_RESET;
            ctrl_c <= CTRL_RESET;
        end else if (wr_en) begin
            if (paddr == ADDR_CTRL_A) ctrl_a <= merge(ctrl_a, pwdata, pstrb);
            if (paddr == ADDR_CTRL_B) ctrl_b <= merge(ctrl_b, pwdata, pstrb);
            if (paddr == ADDR_CTRL_C) ctrl_c <= merge(ctrl_c, pwdata, pstrb);
        end
    end

    always_comb begin
        status                 = 16'h0000;
        status[S_SLEEPING]     = (state != ST_AWAKE);
        status[S_MANUAL]       = (state == ST_MANUAL_SLEEP);
        status[S_SLOW_CLK]     = slow_clock_select;
        status[S_ENERGY]       = energy;
        status[S_QUALIFIED]    = dly.qualified;
        status[S_POWERED_DOWN] = pd;
    end

    // Read data is captured in the setup cycle so it is a flop output in the access cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (psel && !penable) begin
            pslverr <= !is_mapped(paddr);
            case (paddr)
                ADDR_CTRL_A: prdata <= {16'h0000, ctrl_a};
                ADDR_CTRL_B: prdata <= {16'h0000, ctrl_b};
                ADDR_CTRL_C: prdata <= {16'h0000, ctrl_c};
                ADDR_STATUS: prdata <= {16'h0000, status};
                default:     prdata <= 32'h0000_0000;
            endcase
        end else if (!psel) begin
            pslverr <= 1'b0;
        end
    end

    // ************************************************************
    // Energy hold-off
    // ************************************************************
    assign dly.energy   = energy;
    assign dly.long_sel = ctrl_c[C_LONG_DELAY];

    energy_delay_timer #(
        .MIN_CYC (MIN_CYC),
        .INC_CYC (INC_CYC),
        .CNT_W   (16)
    ) u_timer (
        .pclk    (pclk),
        .presetn (presetn),
        .dly     (dly)
    );

    // ************************************************************
    // Ultra-deep sleep control
    // ************************************************************
    always_comb begin
        next_state = state;
        case (state)
            ST_AWAKE: begin
                if (ctrl_c[C_SLEEP_EN]) begin
                    if (ctrl_c[C_METHOD_CPU]) begin
                        if (ctrl_c[C_MANUAL_REQ]) next_state = ST_MANUAL_SLEEP;
                    end else if (!dly.qualified) begin
                        next_state = ST_AUTO_SLEEP;
                    end
                end
            end
            ST_AUTO_SLEEP: begin
                if (!ctrl_c[C_SLEEP_EN] || ctrl_c[C_METHOD_CPU] || energy)
                    next_state = ST_AWAKE;
            end
            // A manual sleep holds until presetn; clearing the request has no effect.
            ST_MANUAL_SLEEP: next_state = ST_MANUAL_SLEEP;
            default:         next_state = ST_AWAKE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= ST_AWAKE;
        end else begin
            state <= next_state;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign indicator_true = !ctrl_c[C_SLEEP_EN] || dly.qualified;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            deep_sleep             <= 1'b0;
            slow_clock_select      <= 1'b0;
            cable_energy_indicator <= 1'b1;
            high_threshold_enable  <= 1'b0;
            rx_termination_disable <= 1'b0;
            nv_copy_enable         <= 1'b0;
        end else begin
            deep_sleep             <= (next_state != ST_AWAKE);
            slow_clock_select      <= (ctrl_a[A_PD_SLOW_CLK] && pd) ||
                                      (ctrl_b[B_UDS_SLOW_CLK] && next_state != ST_AWAKE);
            cable_energy_indicator <= indicator_true ^ ctrl_c[C_DET_POL_LOW];
            high_threshold_enable  <= ctrl_b[B_HIGH_THRESH];
            rx_termination_disable <= ctrl_c[C_RX_TERM_OFF];
            nv_copy_enable         <= ctrl_c[C_NV_ACCESS];
        end
    end

endmodule

`default_nettype wire

// ==== verification/deep_sleep_power_control_sva.sv ====
`timescale 1ns/1ps
`default_nettype none
// ************************************************************
// Checker
// ************************************************************
module deep_sleep_checker
    import deep_sleep_pkg::*;
#(
    parameter int unsigned INC_CYC = 8,
    parameter int unsigned MIN_CYC = 2
) (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0]  pstrb,
    input wire logic        cable_energy,
    input wire logic        deep_sleep,
    input wire logic        slow_clock_select,
    input wire logic        cable_energy_indicator,
    input wire logic        high_threshold_enable,
    input wire logic        rx_termination_disable,
    input wire logic        nv_copy_enable
);
    logic       wr;
    logic       wr_d;
    logic       quiet;
    logic       sh_b15;
    logic       sh_b0;
    logic [6:0] sh_c;
    assign wr = psel && penable && pwrite;
    // Outputs may lag the register by a stage, so they are judged two edges after a write.
    assign quiet = !wr && !wr_d;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_d <= 1'b0;
            sh_b15 <= 1'b0;
            sh_b0 <= 1'b0;
            sh_c <= 7'h00;
        end else begin
            wr_d <= wr;
            if (wr && paddr == ADDR_CTRL_B && pstrb[1]) sh_b15 <= pwdata[15];
            if (wr && paddr == ADDR_CTRL_B && pstrb[0]) sh_b0 <= pwdata[0];
            if (wr && paddr == ADDR_CTRL_C && pstrb[0]) sh_c <= pwdata[6:0];
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_thresh; quiet |-> high_threshold_enable == sh_b15; endproperty
    a_thresh: assert property (p_thresh) else $error("threshold output wrong");
    property p_rxterm; quiet |-> rx_termination_disable == sh_c[2]; endproperty
    a_rxterm: assert property (p_rxterm) else $error("termination output wrong");
    property p_nv; quiet |-> nv_copy_enable == sh_c[4]; endproperty
    a_nv: assert property (p_nv) else $error("copy enable wrong");
    property p_forced; quiet && !sh_c[3] |-> cable_energy_indicator == !sh_c[0]; endproperty
    a_forced: assert property (p_forced) else $error("indicator not forced");
    property p_off; quiet && !sh_c[3] && !$past(deep_sleep) |-> !deep_sleep; endproperty
    a_off: assert property (p_off) else $error("sleep while disabled");
    property p_cpu; quiet && sh_c[6] && !sh_c[5] && !$past(deep_sleep) |-> !deep_sleep;
    endproperty
    a_cpu: assert property (p_cpu) else $error("sleep without request");
    property p_enter;
        wr && paddr == ADDR_CTRL_C && pstrb[0] && pwdata[6] && pwdata[5] && pwdata[3]
            |-> ##[1:2] deep_sleep;
    endproperty
    a_enter: assert property (p_enter) else $error("manual entry missing");
    property p_stay; $rose(deep_sleep) && sh_c[6] |=> deep_sleep [*8]; endproperty
    a_stay: assert property (p_stay) else $error("manual sleep left");
    property p_auto; (sh_c[3] && !sh_c[6] && !sh_c[1] && !cable_energy && !wr) [*8] |-> deep_sleep;
    endproperty
    a_auto: assert property (p_auto) else $error("auto sleep missing");
    property p_slow; quiet && deep_sleep && $past(deep_sleep) && sh_b0 |-> slow_clock_select;
    endproperty
    a_slow: assert property (p_slow) else $error("slow clock missing asleep");
    c_manual: cover property ($rose(deep_sleep) && sh_c[6]);
    c_auto: cover property ($rose(deep_sleep) && !sh_c[6]);
    c_ind: cover property (sh_c[3] && $fell(cable_energy_indicator));
endmodule

bind deep_sleep_power_control deep_sleep_checker #(.INC_CYC(INC_CYC), .MIN_CYC(MIN_CYC)) u_chk (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .cable_energy,
    .deep_sleep, .slow_clock_select, .cable_energy_indicator, .high_threshold_enable,
    .rx_termination_disable, .nv_copy_enable);
`default_nettype wire

// ==== verification/deep_sleep_power_control_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
// ************************************************************
// Bench
// ************************************************************
module deep_sleep_power_control_tb;
    import deep_sleep_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic cable_energy = 1, powered_down = 0, e;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, d;
    logic [3:0]  pstrb = 4'hF;
    logic pready, pslverr, slow_clock_select, deep_sleep, ind, thr, rxt, nv;
    int errors = 0, checks = 0;
    // Small hold-off counts keep the energy-loss scenarios short.
    deep_sleep_power_control #(.INC_CYC(8), .MIN_CYC(2)) DUT (.pclk, .presetn, .psel,
        .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .cable_energy,
        .powered_down, .slow_clock_select, .deep_sleep, .cable_energy_indicator(ind),
        .high_threshold_enable(thr), .rx_termination_disable(rxt), .nv_copy_enable(nv));
    initial begin
        forever #5 pclk = ~pclk;
    end
    task automatic final_report;
        if (errors == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask
    // The master holds the request until pready is seen high at a rising edge.
    // Read data and error are taken at the very edge at which pready is seen high.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        int n;
        @(posedge pclk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) errors++;
        d = prdata;
        e = pslverr;
        psel <= 0;
        penable <= 0;
        cyc(1);
    endtask
    task automatic do_reset;
        presetn <= 0;
        cyc(3);
        presetn <= 1;
        cyc(1);
    endtask
    task automatic t_reset;
        apb(0, ADDR_CTRL_A, 0); check(d, 0);
        apb(0, ADDR_CTRL_B, 0); check(d, 0);
        apb(0, ADDR_CTRL_C, 0); check(d, 0);
        check(ind, 1);
    endtask
    task automatic t_regs;
        apb(1, ADDR_CTRL_B, 32'h8000);
        apb(1, ADDR_CTRL_C, 32'h17);
        cyc(2);
        check(thr, 1);
        check(rxt, 1);
        check(nv, 1);
        apb(0, ADDR_CTRL_C, 0); check(d, 32'h17);
        apb(1, 8'hF0, 32'hFFFF);
        apb(0, 8'hF0, 0); check(d, 0); check(e, 1);
        apb(1, ADDR_CTRL_B, 0);
        apb(1, ADDR_CTRL_C, 0);
        cyc(2);
        check({thr, rxt, nv}, 0);
    endtask
    task automatic t_pd;
        apb(1, ADDR_CTRL_A, 32'h40);
        powered_down <= 1; cyc(5); check(slow_clock_select, 1);
        powered_down <= 0; cyc(5); check(slow_clock_select, 0);
        apb(1, ADDR_CTRL_A, 0);
        powered_down <= 1; cyc(5); check(slow_clock_select, 0);
        powered_down <= 0;
    endtask
    task automatic t_ind;
        apb(1, ADDR_CTRL_C, 32'h58); cyc(8); check(ind, 1);
        cable_energy <= 0; cyc(12); check(ind, 0);
        check(deep_sleep, 0);
        apb(1, ADDR_CTRL_C, 32'h59); cyc(2); check(ind, 1);
        apb(1, ADDR_CTRL_C, 32'h5A); cable_energy <= 1; cyc(12);
        cable_energy <= 0; cyc(6); check(ind, 1);
        cyc(14); check(ind, 0);
        apb(1, ADDR_CTRL_C, 32'h50); cyc(2); check(ind, 1);
        cable_energy <= 1; cyc(4);
    endtask
    task automatic t_auto;
        apb(1, ADDR_CTRL_B, 32'h1);
        apb(1, ADDR_CTRL_C, 32'h18);
        cable_energy <= 0; cyc(20);
        check(deep_sleep, 1);
        check(slow_clock_select, 1);
        apb(0, ADDR_CTRL_C, 0); check(d, 32'h18);
        apb(0, ADDR_STATUS, 0); check(d, 32'h5);
        cable_energy <= 1; cyc(8); check(deep_sleep, 0);
    endtask
    task automatic t_manual;
        apb(1, ADDR_CTRL_C, 32'h58);
        apb(1, ADDR_CTRL_C, 32'h78); check(deep_sleep, 1);
        apb(1, ADDR_CTRL_C, 32'h58); cyc(10); check(deep_sleep, 1);
        do_reset; check(deep_sleep, 0);
        apb(0, ADDR_CTRL_C, 0); check(d, 0);
    endtask
    initial begin
        repeat (3) @(posedge pclk);
        #1;
        presetn <= 1;
        cyc(1);
        t_reset;
        t_regs;
        t_pd;
        t_ind;
        t_auto;
        t_manual;
        final_report;
    end
    initial begin
        repeat (5000) @(posedge pclk);
        errors++;
        final_report;
    end
endmodule
`default_nettype wire
